// ==== include/tcch_consts.vh ====
// Purpose: Shared constants of the tag custom command handler.
// Assumes: Included by bare name; definitions only.
// Notes: Block numbers index 32-bit configuration words.
`ifndef TCCH_CONSTS_VH
`define TCCH_CONSTS_VH

// Command codes.
`define TCCH_CMD_PROTECT 8'hA6
`define TCCH_CMD_WR_EASID 8'hA7
`define TCCH_CMD_SYSINFO 8'hAB
`define TCCH_CMD_QUIET_P 8'hBC
`define TCCH_CMD_READ_SIG 8'hBD
`define TCCH_CMD_READ_CFG 8'hC0
`define TCCH_CMD_SELECT 8'h25
`define TCCH_CMD_RST_READY 8'h26

// Request flag bit positions.
`define TCCH_FLG_INV 2
`define TCCH_FLG_SEL 4
`define TCCH_FLG_AFI 4
`define TCCH_FLG_ADR 5
`define TCCH_FLG_OPT 6

// Response flag bytes and error code.
`define TCCH_RSP_OK 8'h00
`define TCCH_RSP_ERR 8'h01
`define TCCH_ERR_CODE 8'h0F

// Configuration block numbers.
`define TCCH_BLK_PP 7'd16
`define TCCH_BLK_EASID 7'd18
`define TCCH_BLK_AFI_PP 7'd28
`define TCCH_BLK_EAS_PP 7'd29
`define TCCH_BLK_LOCKS 7'd30
`define TCCH_BLK_SIGCFG 7'd38
`define TCCH_BLK_PWD_FIRST 7'd41
`define TCCH_BLK_PWD_LAST 7'd46
`define TCCH_BLK_OPEN_MSG 7'd47

// Field bit positions.
`define TCCH_BIT_PWD_EN 0
`define TCCH_BIT_SIG_LONG 0
`define TCCH_BIT_LOCK_AFI 0
`define TCCH_BIT_LOCK_EAS 1
`define TCCH_BIT_OPEN_LOCK 8

// Payload lengths in bytes.
`define TCCH_LEN_SYSINFO 10'd7
`define TCCH_LEN_SIG_SHORT 10'd32
`define TCCH_LEN_SIG_LONG 10'd48

// Status word index on the register port and reset value of memory.
`define TCCH_IDX_STATUS 8'h80
`define TCCH_CFG_RESET 32'h0000_0000

// Write-alike timing.
`define TCCH_WRITE_TIME_NS 20000
`define TCCH_CLK_PERIOD_NS 20
`define TCCH_WRITE_CYC \
	((`TCCH_WRITE_TIME_NS + `TCCH_CLK_PERIOD_NS - 1) / `TCCH_CLK_PERIOD_NS)

`endif

// ==== src/tcch_cmd.v ====
// Purpose: Custom command handler of a contactless label: protection,
//          EAS identifier, system information, persistent quiet,
//          signature and configuration reads.
// Assumes: The RF layer hands over decoded, CRC-checked frames already
//          matched to this tag's UID, and appends CRC16 to each reply.
// Notes: Replies leave as a byte stream, flags byte first.
`timescale 1ns/100ps
`include "tcch_consts.vh"

module tcch_cmd #(
	parameter [31:0] FEATURES = 32'h0000_FFFF, // Enabled feature bits.
	parameter WRITE_CYC = `TCCH_WRITE_CYC // Write-alike delay in cycles.
) (
	input wire clock, // 50 MHz clock.
	input wire rst_n, // Asynchronous reset, long power loss.
	input wire req_valid, // One-cycle pulse: a request frame is here.
	input wire [7:0] req_flags, // Request flags byte.
	input wire [7:0] req_cmd, // Command code.
	input wire [7:0] req_p0, // Block address or EAS ID low byte.
	input wire [7:0] req_p1, // Block count minus one or EAS ID high byte.
	input wire [1:0] req_xquiet, // Extended quiet and persistent quiet bits.
	input wire eas_afi_auth, // Level: EAS/AFI password was accepted.
	output wire req_taken, // High when this request is processed.
	output wire busy, // High while a reply or write is pending.
	output reg rsp_valid_q, // Reply byte valid.
	output reg [7:0] rsp_data_q, // Reply byte.
	output reg rsp_last_q, // Last reply byte, CRC follows.
	input wire rsp_ready, // Framer takes the reply byte.
	output wire persist_quiet, // Level: persistent quiet state.
	output wire eas_protected, // Level: EAS password protection on.
	output wire afi_protected, // Level: AFI password protection on.
	input wire [7:0] cfg_addr, // Register port word index.
	input wire [31:0] cfg_wdata, // Register port write data.
	input wire cfg_wr, // Register port write strobe.
	input wire cfg_rd, // Register port read strobe.
	output reg [31:0] cfg_rdata_q // Read data, one cycle after the strobe.
);

	localparam S_IDLE = 2'd0;
	localparam S_WAIT = 2'd1;
	localparam S_SEND = 2'd2;
	localparam M_ERR = 2'd0;
	localparam M_DATA = 2'd1;
	localparam M_SYS = 2'd2;
	localparam W_EAS = 2'd1;
	localparam W_AFI = 2'd2;
	localparam W_ID = 2'd3;

	reg [31:0] mem [0:127];
	reg [1:0] state_q;
	reg [1:0] mode_q;
	reg [1:0] wkind_q;
	reg [15:0] wval_q;
	reg [9:0] idx_q;
	reg [9:0] len_q;
	reg [6:0] base_q;
	reg [31:0] timer_q;
	reg persist_q;
	reg [7:0] byte_d;
	reg [31:0] blk_word;
	reg [6:0] blk_num;
	reg [9:0] pidx;
	reg [6:0] cmd_blk;
	reg [31:0] cmd_word;
	reg cmd_we;
	integer i;

	wire f_inv = req_flags[`TCCH_FLG_INV];
	wire f_adr = !f_inv && req_flags[`TCCH_FLG_ADR];
	wire f_sel = !f_inv && req_flags[`TCCH_FLG_SEL];
	wire f_afi = f_inv && req_flags[`TCCH_FLG_AFI];
	wire f_opt = req_flags[`TCCH_FLG_OPT];
	wire may_err = f_adr || f_sel;
	wire [31:0] w_locks = mem[`TCCH_BLK_LOCKS];
	wire eas_locked = w_locks[`TCCH_BIT_LOCK_EAS];
	wire sig_long = mem[`TCCH_BLK_SIGCFG][`TCCH_BIT_SIG_LONG];
	wire [8:0] rd_end = {1'b0, req_p0} + {1'b0, req_p1};
	wire timer_done = (timer_q == 32'h0000_0000);

	// Protection state lives in the enable bits themselves, so a config
	// write and the protect command both reach it.
	assign eas_protected = mem[`TCCH_BLK_EAS_PP][`TCCH_BIT_PWD_EN];
	assign afi_protected = mem[`TCCH_BLK_AFI_PP][`TCCH_BIT_PWD_EN];
	assign persist_quiet = persist_q;
	assign busy = (state_q != S_IDLE);

	// Inventory requests are dropped in persistent quiet unless AFI is
	// given or both quiet bits are set; all else passes.
	assign req_taken = req_valid && (state_q == S_IDLE) &&
		(!persist_q || !f_inv || f_afi || (req_xquiet == 2'b11));

	// Masked read of one configuration block for replies.
	function [31:0] cfg_view;
		input [6:0] blk;
		input [31:0] word;
		input open_lock;
		begin
			if (blk >= `TCCH_BLK_PWD_FIRST && blk <= `TCCH_BLK_PWD_LAST)
				cfg_view = 32'h0000_0000;
			else if (blk == `TCCH_BLK_OPEN_MSG && open_lock)
				cfg_view = 32'h0000_0000;
			else
				cfg_view = word;
		end
	endfunction

	// Select byte n (LSB first) of a word.
	function [7:0] byte_of;
		input [31:0] word;
		input [1:0] n;
		begin
			byte_of = word[8 * n +: 8];
		end
	endfunction

	// Reply byte for the current index; index 0 is the flags byte.
	always @*
	begin
		pidx = idx_q - 10'd1;
		blk_num = base_q + pidx[8:2];
		blk_word = cfg_view(blk_num, mem[blk_num],
			w_locks[`TCCH_BIT_OPEN_LOCK]);
		byte_d = 8'h00;
		case (mode_q)
			M_ERR:
				byte_d = (idx_q == 10'd0) ? `TCCH_RSP_ERR : `TCCH_ERR_CODE;
			M_DATA:
				byte_d = (idx_q == 10'd0) ? `TCCH_RSP_OK :
					byte_of(blk_word, pidx[1:0]);
			M_SYS:
			begin
				case (idx_q[2:0])
					3'd0: byte_d = `TCCH_RSP_OK;
					3'd1: byte_d = byte_of(mem[`TCCH_BLK_PP], 2'd0);
					3'd2: byte_d = byte_of(mem[`TCCH_BLK_PP], 2'd1) &
						8'h33;
					3'd3: byte_d = {4'h0, w_locks[3:0]};
					// Reserved bits forced to zero; bit 31 stays as set,
					// though no extra word is ever sent.
					3'd4: byte_d = FEATURES[7:0];
					3'd5: byte_d = FEATURES[15:8];
					3'd6: byte_d = 8'h00;
					default: byte_d = {FEATURES[31], 7'h00};
				endcase
			end
			default: byte_d = 8'h00;
		endcase
	end

	// Command-side memory write at the end of the write-alike delay.
	always @*
	begin
		cmd_we = (state_q == S_WAIT) && timer_done && !cfg_wr;
		cmd_blk = `TCCH_BLK_EASID;
		cmd_word = mem[`TCCH_BLK_EASID];
		case (wkind_q)
			W_EAS:
			begin
				cmd_blk = `TCCH_BLK_EAS_PP;
				cmd_word = mem[`TCCH_BLK_EAS_PP] |
					(32'h0000_0001 << `TCCH_BIT_PWD_EN);
			end
			W_AFI:
			begin
				cmd_blk = `TCCH_BLK_AFI_PP;
				cmd_word = mem[`TCCH_BLK_AFI_PP] |
					(32'h0000_0001 << `TCCH_BIT_PWD_EN);
			end
			W_ID:
				cmd_word = {mem[`TCCH_BLK_EASID][31:16], wval_q};
			default: cmd_we = 1'b0;
		endcase
	end

	// Configuration memory. The bus write wins a clash; the command write
	// then waits until cfg_wr drops so that no software write is ever lost.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < 128; i = i + 1)
				mem[i] <= `TCCH_CFG_RESET;
		end
		else if (cfg_wr && !cfg_addr[7])
		begin
			// Protection enable bits are one-way: old ones are kept.
			if (cfg_addr[6:0] == `TCCH_BLK_EAS_PP ||
				cfg_addr[6:0] == `TCCH_BLK_AFI_PP)
				mem[cfg_addr[6:0]] <= cfg_wdata | (mem[cfg_addr[6:0]] &
					(32'h0000_0001 << `TCCH_BIT_PWD_EN));
			else
				mem[cfg_addr[6:0]] <= cfg_wdata;
		end
		else if (cmd_we)
			mem[cmd_blk] <= cmd_word;
	end

	// Register port read: memory words, then the status word, else zero.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg_rdata_q <= 32'h0000_0000;
		else if (cfg_rd)
		begin
			if (!cfg_addr[7])
				cfg_rdata_q <= mem[cfg_addr[6:0]];
			else if (cfg_addr == `TCCH_IDX_STATUS)
				cfg_rdata_q <= {28'h0, afi_protected, eas_protected,
					busy, persist_q};
			else
				cfg_rdata_q <= 32'h0000_0000;
		end
	end

	// Request decode, write-alike wait and reply sequencing.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			mode_q <= M_ERR;
			wkind_q <= 2'd0;
			wval_q <= 16'h0000;
			idx_q <= 10'd0;
			len_q <= 10'd0;
			base_q <= 7'd0;
			timer_q <= 32'h0000_0000;
			persist_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 8'h00;
			rsp_last_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				S_IDLE:
				begin
					idx_q <= 10'd0;
					len_q <= 10'd0;
					mode_q <= M_ERR;
					if (req_taken)
					begin
						case (req_cmd)
							`TCCH_CMD_PROTECT:
							begin
								if (eas_afi_auth)
								begin
									wkind_q <= f_opt ? W_AFI : W_EAS;
									timer_q <= WRITE_CYC;
									state_q <= S_WAIT;
								end
								else if (may_err)
									state_q <= S_SEND;
							end
							`TCCH_CMD_WR_EASID:
							begin
								if (!eas_locked &&
									(!eas_protected || eas_afi_auth))
								begin
									wkind_q <= W_ID;
									wval_q <= {req_p1, req_p0};
									timer_q <= WRITE_CYC;
									state_q <= S_WAIT;
								end
								else if (may_err)
									state_q <= S_SEND;
							end
							`TCCH_CMD_SYSINFO:
							begin
								mode_q <= M_SYS;
								len_q <= `TCCH_LEN_SYSINFO;
								state_q <= S_SEND;
							end
							`TCCH_CMD_QUIET_P:
							begin
								// Only honoured when sent addressed.
								if (f_adr && !req_flags[`TCCH_FLG_SEL])
									persist_q <= 1'b1;
							end
							`TCCH_CMD_READ_SIG:
							begin
								mode_q <= M_DATA;
								base_q <= 7'd0;
								len_q <= sig_long ? `TCCH_LEN_SIG_LONG :
									`TCCH_LEN_SIG_SHORT;
								state_q <= S_SEND;
							end
							`TCCH_CMD_READ_CFG:
							begin
								// Option 1 and ranges past block 127 fail.
								if (!f_opt && rd_end[8:7] == 2'b00)
								begin
									mode_q <= M_DATA;
									base_q <= req_p0[6:0];
									len_q <= {req_p1[7:0], 2'b00} +
										10'd4;
									state_q <= S_SEND;
								end
								else if (may_err)
									state_q <= S_SEND;
							end
							`TCCH_CMD_SELECT,
							`TCCH_CMD_RST_READY:
								persist_q <= 1'b0;
							default:
								state_q <= S_IDLE;
						endcase
					end
				end
				S_WAIT:
				begin
					// Write-alike: the flags byte follows the stored write.
					if (!timer_done)
						timer_q <= timer_q - 32'h0000_0001;
					else if (cmd_we)
					begin
						mode_q <= M_DATA;
						len_q <= 10'd0;
						state_q <= S_SEND;
					end
				end
				S_SEND:
				begin
					if (!rsp_valid_q || rsp_ready)
					begin
						if (rsp_valid_q && rsp_last_q)
						begin
							rsp_valid_q <= 1'b0;
							rsp_last_q <= 1'b0;
							wkind_q <= 2'd0;
							state_q <= S_IDLE;
						end
						else
						begin
							rsp_valid_q <= 1'b1;
							rsp_data_q <= byte_d;
							rsp_last_q <= (mode_q == M_ERR) ?
								(idx_q == 10'd1) : (idx_q == len_q);
							idx_q <= idx_q + 10'd1;
						end
					end
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

endmodule // tcch_cmd

// ==== verification/tcch_cmd_properties.sv ====
// Purpose: Port checks of the command handler.
// Assumes: One clock, reset active low.
// Notes: Bound below to every handler instance.
`timescale 1ns/100ps
module tcch_cmd_properties (
	input wire clock, // Clock.
	input wire rst_n, // Reset.
	input wire req_valid, // Request.
	input wire [7:0] req_flags, // Flags.
	input wire [7:0] req_cmd, // Command.
	input wire [1:0] req_xquiet, // Quiet bits.
	input wire req_taken, // Taken.
	input wire busy, // Busy.
	input wire rsp_valid_q, // Byte valid.
	input wire [7:0] rsp_data_q, // Byte.
	input wire rsp_last_q, // Last byte.
	input wire rsp_ready, // Byte taken.
	input wire persist_quiet, // Quiet.
	input wire eas_protected, // EAS protected.
	input wire afi_protected // AFI protected.
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Idle quiet offers, and non-inventory requests that were taken.
	wire pq = persist_quiet && req_valid && !busy;
	wire tk_c = req_taken && !req_flags[2];
	a_quiet_filter: assert property (
		pq && req_flags[2] |-> req_taken == (req_flags[4] || &req_xquiet))
		else $error("quiet filter wrong");
	a_quiet_serve: assert property (
		pq && !req_flags[2] && |req_flags[5:4] |-> req_taken)
		else $error("quiet tag refused request");
	a_quiet_enter: assert property (
		tk_c && req_cmd == 8'hBC && req_flags[5:4] == 2'b10 |=> persist_quiet)
		else $error("quiet not entered");
	a_quiet_silent: assert property (
		req_taken && req_cmd == 8'hBC |=> !rsp_valid_q [*4])
		else $error("quiet command replied");
	a_quiet_exit: assert property (
		req_taken && (req_cmd == 8'h25 || req_cmd == 8'h26) |=> !persist_quiet)
		else $error("quiet not left");
	a_eas_sticky: assert property (eas_protected |=> eas_protected)
		else $error("EAS protection cleared");
	a_afi_sticky: assert property (afi_protected |=> afi_protected)
		else $error("AFI protection cleared");
	a_info_head: assert property (
		tk_c && req_cmd == 8'hAB |-> ##2 rsp_valid_q && rsp_data_q == 8'h00)
		else $error("info reply head wrong");
	a_byte_hold: assert property (
		rsp_valid_q && !rsp_ready |=> rsp_valid_q && $stable(rsp_data_q))
		else $error("reply byte not held");
	a_last_ends: assert property (
		rsp_valid_q && rsp_ready && rsp_last_q |=> !rsp_valid_q)
		else $error("reply ran past last byte");
	a_cfg_option: assert property (
		tk_c && req_cmd == 8'hC0 && req_flags[6] && req_flags[5]
		|-> ##2 rsp_valid_q && rsp_data_q == 8'h01)
		else $error("option read not refused");
	// Main scenarios reached.
	c_info: cover property (tk_c && req_cmd == 8'hAB);
	c_quiet: cover property ($rose(persist_quiet));
	c_afi: cover property ($rose(afi_protected));
endmodule // tcch_cmd_properties

bind tcch_cmd tcch_cmd_properties chk (.clock, .rst_n, .req_valid,
	.req_flags, .req_cmd, .req_xquiet, .req_taken, .busy, .rsp_valid_q,
	.rsp_data_q, .rsp_last_q, .rsp_ready, .persist_quiet, .eas_protected,
	.afi_protected);

// ==== verification/tcch_reader.sv ====
// Purpose: Reader-side model that takes reply bytes.
// Assumes: One reply at a time.
// Notes: Slow mode stalls every other cycle.
`timescale 1ns/100ps
module tcch_reader (
	input wire clock, // Clock.
	input wire slow, // Stall mode.
	input wire rsp_valid_q, // Byte valid.
	input wire [7:0] rsp_data_q, // Byte.
	input wire rsp_last_q, // Final byte of a reply.
	output reg rsp_ready = 1'b0 // Byte taken.
);
	reg [7:0] got [0:511];
	integer n = 0;
	integer last_n = 0;
	// A stalled byte must stand, so slow mode keeps the handler waiting.
	always @(posedge clock)
	begin
		rsp_ready <= slow ? ~rsp_ready : 1'b1;
		if (rsp_valid_q && rsp_ready)
		begin
			got[n] <= rsp_data_q;
			n <= n + 1;
			// Byte count at the marked end, so the bench can see it matches.
			if (rsp_last_q)
				last_n <= n + 1;
		end
	end
endmodule // tcch_reader

// ==== verification/tcch_cmd_test.sv ====
// Purpose: Self-checking bench of the command handler.
// Assumes: Short write-alike delay; reader model stores replies.
// Notes: Status word is {afi, eas, busy, quiet}.
`timescale 1ns/100ps
module tcch_cmd_test;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg req_valid = 1'b0;
	reg [7:0] req_flags = 8'h00;
	reg [7:0] req_cmd = 8'h00;
	reg [7:0] req_p0 = 8'h00;
	reg [7:0] req_p1 = 8'h00;
	reg [1:0] req_xquiet = 2'b00;
	reg eas_afi_auth = 1'b0;
	reg [7:0] cfg_addr = 8'h00;
	reg [31:0] cfg_wdata = 32'h0000_0000;
	reg cfg_wr = 1'b0;
	reg cfg_rd = 1'b0;
	reg slow = 1'b0;
	reg [31:0] tk;
	reg [31:0] rv;
	reg [7:0] k;
	integer bad_count = 0;
	integer total_checks = 0;
	integer base = 0;
	wire req_taken, busy, rsp_valid_q, rsp_last_q, rsp_ready;
	wire persist_quiet, eas_protected, afi_protected;
	wire [7:0] rsp_data_q;
	wire [31:0] cfg_rdata_q;
	// Handler under test and the reader that drains it.
	tcch_cmd #(.WRITE_CYC(4)) dut (.clock, .rst_n, .req_valid, .req_flags,
		.req_cmd, .req_p0, .req_p1, .req_xquiet, .eas_afi_auth, .req_taken,
		.busy, .rsp_valid_q, .rsp_data_q, .rsp_last_q, .rsp_ready,
		.persist_quiet, .eas_protected, .afi_protected, .cfg_addr,
		.cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata_q);
	tcch_reader rdr (.clock, .slow, .rsp_valid_q, .rsp_data_q, .rsp_last_q,
		.rsp_ready);
	// Clock of 20 ns.
	always #10 clock = ~clock;
	task conclude;
	begin
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// Compares c reply bytes from offset o against v, low byte first.
	task seq(input [63:0] v, input integer c, input integer o);
		integer j;
		for (j = 0; j < c; j = j + 1)
			chk("byte", {24'h00_0000, rdr.got[base + o + j]},
				{24'h00_0000, v[8 * j +: 8]});
	endtask
	// Reply length, and the end mark on the final byte taken.
	task ln(input integer c);
	begin
		chk("length", rdr.n - base, c);
		chk("last", rdr.last_n, rdr.n);
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge clock);
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_wr <= 1'b1;
		@(posedge clock);
		cfg_wr <= 1'b0;
	end
	endtask
	task rd(input [7:0] a);
	begin
		@(posedge clock);
		cfg_addr <= a;
		cfg_rd <= 1'b1;
		@(posedge clock);
		cfg_rd <= 1'b0;
		#1;
		rv = cfg_rdata_q;
	end
	endtask
	// One request pulse, then a bounded wait until the handler is idle.
	task req(input [7:0] f, input [7:0] c, input [7:0] a, input [7:0] b,
		input [1:0] x);
		integer w;
	begin
		@(posedge clock);
		{req_flags, req_cmd, req_p0, req_p1, req_xquiet} <= {f, c, a, b, x};
		req_valid <= 1'b1;
		base = rdr.n;
		#1;
		tk = {31'h0000_0000, req_taken};
		@(posedge clock);
		req_valid <= 1'b0;
		repeat (3) @(posedge clock);
		for (w = 0; busy !== 1'b0 && w < 500; w = w + 1)
			@(posedge clock);
		if (w == 500)
		begin
			bad_count = bad_count + 1;
			conclude;
		end
	end
	endtask
	initial
	begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		// System information read while the reader stalls.
		wr(8'h10, 32'h0000_FF12);
		wr(8'h1E, 32'h0000_001F);
		slow <= 1'b1;
		req(8'h20, 8'hAB, 8'h00, 8'h00, 2'b00);
		ln(8);
		seq(64'h0000_FFFF_0F33_1200, 8, 0);
		slow <= 1'b0;
		// Two blocks, the second a password block, then the open message.
		wr(8'h28, 32'h4433_2211);
		wr(8'h29, 32'h5566_7788);
		req(8'h20, 8'hC0, 8'h28, 8'h01, 2'b00);
		ln(9);
		seq(64'h0000_0000_4433_2211, 8, 1);
		wr(8'h2F, 32'hA5A5_5A5A);
		req(8'h20, 8'hC0, 8'h2F, 8'h00, 2'b00);
		seq(64'h0000_00A5_A55A_5A00, 5, 0);
		wr(8'h1E, 32'h0000_011F);
		req(8'h20, 8'hC0, 8'h2F, 8'h00, 2'b00);
		seq(64'h0000_0000_0000_0000, 5, 0);
		// Refused reads: option flag and a range past block 127.
		req(8'h60, 8'hC0, 8'h00, 8'h00, 2'b00);
		seq(64'h0000_0000_0000_0F01, 2, 0);
		req(8'h20, 8'hC0, 8'h7F, 8'h01, 2'b00);
		seq(64'h0000_0000_0000_0F01, 2, 0);
		req(8'h20, 8'hC0, 8'h80, 8'h80, 2'b00);
		seq(64'h0000_0000_0000_0F01, 2, 0);
		// Signature in both lengths, block k filled with byte k.
		for (k = 8'h00; k < 8'h0C; k = k + 8'h01)
			wr(k, {4{k}});
		req(8'h20, 8'hBD, 8'h00, 8'h00, 2'b00);
		ln(33);
		seq(64'h0000_0007_0707_0706, 5, 28);
		wr(8'h26, 32'h0000_0001);
		req(8'h20, 8'hBD, 8'h00, 8'h00, 2'b00);
		ln(49);
		seq(64'h0000_000B_0B0B_0B0A, 5, 44);
		// EAS identifier, refused while locked, then written once unlocked.
		req(8'h20, 8'hA7, 8'h34, 8'h12, 2'b00);
		seq(64'h0000_0000_0000_0F01, 2, 0);
		wr(8'h1E, 32'h0000_0100);
		req(8'h20, 8'hA7, 8'h34, 8'h12, 2'b00);
		seq(64'h0000_0000_0000_0000, 1, 0);
		// Protection with and without the password.
		req(8'h20, 8'hA6, 8'h00, 8'h00, 2'b00);
		rd(8'h80);
		chk("status", rv, 32'h0000_0000);
		eas_afi_auth <= 1'b1;
		req(8'h60, 8'hA6, 8'h00, 8'h00, 2'b00);
		seq(64'h0000_0000_0000_0000, 1, 0);
		ln(1);
		rd(8'h80);
		chk("status", rv, 32'h0000_0008);
		req(8'h20, 8'hA6, 8'h00, 8'h00, 2'b00);
		wr(8'h1D, 32'h0000_0000);
		wr(8'h1C, 32'h0000_0000);
		rd(8'h80);
		chk("status", rv, 32'h0000_000C);
		eas_afi_auth <= 1'b0;
		req(8'h20, 8'hA7, 8'h78, 8'h56, 2'b00);
		rd(8'h12);
		chk("eas id", {16'h0000, rv[15:0]}, 32'h0000_1234);
		// Persistent quiet: filtering, serving and every way out.
		req(8'h20, 8'hBC, 8'h00, 8'h00, 2'b00);
		ln(0);
		req(8'h04, 8'hAB, 8'h00, 8'h00, 2'b00);
		chk("taken", tk, 32'h0000_0000);
		req(8'h14, 8'hAB, 8'h00, 8'h00, 2'b00);
		chk("taken", tk, 32'h0000_0001);
		req(8'h04, 8'hAB, 8'h00, 8'h00, 2'b11);
		chk("taken", tk, 32'h0000_0001);
		req(8'h20, 8'hAB, 8'h00, 8'h00, 2'b00);
		chk("taken", tk, 32'h0000_0001);
		req(8'h20, 8'h25, 8'h00, 8'h00, 2'b00);
		rd(8'h80);
		chk("status", rv, 32'h0000_000C);
		req(8'h20, 8'hBC, 8'h00, 8'h00, 2'b00);
		req(8'h20, 8'h26, 8'h00, 8'h00, 2'b00);
		rd(8'h80);
		chk("status", rv, 32'h0000_000C);
		req(8'h20, 8'hBC, 8'h00, 8'h00, 2'b00);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		wr(8'h1C, 32'h0000_0001);
		rd(8'h80);
		chk("status", rv, 32'h0000_0008);
		conclude;
	end
endmodule // tcch_cmd_test
